// [hw/gql_pkg.sv]
// constants and types shared by the input qualifier and low-power sequencer
package gql_pkg;
    // ------------------------------------------------------------------
    // pin grouping and qualification
    // ------------------------------------------------------------------
    localparam int unsigned NUM_PINS    = 16;
    localparam int unsigned GROUP_PINS  = 8;
    localparam int unsigned NUM_GROUPS  = NUM_PINS / GROUP_PINS;
    localparam int unsigned PERIOD_W    = 8;
    localparam int unsigned PCNT_W      = PERIOD_W + 1;
    localparam int unsigned SAMPLES_MAX = 6;
    localparam logic [PCNT_W-1:0]      PCNT_RST     = 9'h000;
    localparam logic [SAMPLES_MAX-1:0] SAMPLES_RST  = 6'h00;
    localparam logic                   QUAL_RST     = 1'b0;
    // ------------------------------------------------------------------
    // low-power entry and exit, counts in system clock cycles
    // ------------------------------------------------------------------
    localparam int unsigned ENT_W = 7;
    localparam logic [ENT_W-1:0] HOLD_SHORT   = 7'h10;  // 16 cycles
    localparam logic [ENT_W-1:0] HOLD_MID     = 7'h20;  // 32 cycles
    localparam logic [ENT_W-1:0] HOLD_LONG    = 7'h40;  // 64 cycles
    localparam logic [ENT_W-1:0] CLKOUT_LOW   = 7'h20;  // 32 cycles
    localparam logic [ENT_W-1:0] ENT_MAX      = 7'h7F;
    localparam int unsigned LAT_W = 11;
    localparam logic [LAT_W-1:0] LAT_IDLE_FAST = 11'h014;  // 20 cycles
    localparam logic [LAT_W-1:0] LAT_IDLE_SLOW = 11'h41A;  // 1050 cycles
    localparam logic [LAT_W-1:0] LAT_SB_FAST   = 11'h064;  // 100 cycles
    localparam logic [LAT_W-1:0] LAT_SB_SLOW   = 11'h465;  // 1125 cycles
    // ------------------------------------------------------------------
    // oscillator clock counts and low-power mode codes
    // ------------------------------------------------------------------
    localparam logic [2:0] OSC_GUARD    = 3'h4;
    localparam int unsigned WQ_W         = 7;
    localparam logic [WQ_W-1:0] SB_QUAL_BASE = 7'h02;
    localparam logic [1:0] MODE_IDLE    = 2'h1;
    localparam logic [1:0] MODE_STANDBY = 2'h2;
    // ------------------------------------------------------------------
    // sequencer states
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_RUN,
        ST_IDLE,
        ST_SB_HOLD,
        ST_STANDBY,
        ST_RESUME
    } gql_lpm_state_t;
endpackage

// [hw/gql_qual_if.sv]
// signals between the group sampler and one pin qualifier
`timescale 1ns/1ps
interface gql_qual_if;
    logic tick;
    logic six_sample;
    logic pin_raw;
    logic qualified;
    modport qual (input tick, input six_sample, input pin_raw, output qualified);
    modport ctrl (output tick, output six_sample, output pin_raw, input qualified);
endinterface

// [hw/gql_qualifier.sv]
// one pin: three-flop synchroniser, sample window and qualified level
`timescale 1ns/1ps
module gql_qualifier (
    // clock and reset
    input  wire logic      i_ref_clk,
    input  wire logic      i_rst_n,
    // group side
    gql_qual_if.qual       q
);
    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    logic [2:0]                       sync;
    logic [2:0]                       next_sync;
    logic                             level;
    logic                             next_level;
    logic [gql_pkg::SAMPLES_MAX-1:0]  samples;
    logic [gql_pkg::SAMPLES_MAX-1:0]  next_samples;
    logic                             qual;
    logic                             next_qual;

    // next values: sync, stable level, sample shift and agreement check
    always_comb begin
        next_sync    = {sync[1:0], q.pin_raw};
        next_level   = (sync[1] == sync[2]) ? sync[2] : level;
        next_samples = samples;
        next_qual    = qual;
        if (q.tick) begin
            next_samples = {samples[gql_pkg::SAMPLES_MAX-2:0], level};
            if (q.six_sample) begin
                if (&next_samples || ~|next_samples) begin
                    next_qual = next_samples[0];
                end
            end else if (&next_samples[2:0] || ~|next_samples[2:0]) begin
                next_qual = next_samples[0];
            end
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            sync    <= 3'h0;
            level   <= gql_pkg::QUAL_RST;
            samples <= gql_pkg::SAMPLES_RST;
            qual    <= gql_pkg::QUAL_RST;
        end else begin
            sync    <= next_sync;
            level   <= next_level;
            samples <= next_samples;
            qual    <= next_qual;
        end
    end

    assign q.qualified = qual;

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    property p_qual_agree;
        @(posedge i_ref_clk) disable iff (!i_rst_n)
        $changed(qual) |-> ($past(q.tick) &&
            (q.six_sample ? (samples == {6{qual}}) : (samples[2:0] == {3{qual}})));
    endproperty
    a_qual_agree: assert property (p_qual_agree) else $error("qualified moved without agreement");

    property p_qual_hold;
        @(posedge i_ref_clk) disable iff (!i_rst_n)
        !$past(q.tick) |-> $stable(qual);
    endproperty
    a_qual_hold: assert property (p_qual_hold) else $error("qualified moved off a sample tick");
endmodule

// [hw/gql_top.sv]
// input qualification for pin groups and low-power entry and wake sequencer
`timescale 1ns/1ps
module gql_top (
    // clock and reset
    input  wire logic                                                  i_ref_clk,
    input  wire logic                                                  i_rst_n,
    // pins and qualification setup
    input  wire logic [gql_pkg::NUM_PINS-1:0]                          i_gpio_pin,
    input  wire logic [gql_pkg::NUM_GROUPS*gql_pkg::PERIOD_W-1:0]      i_qual_period,
    input  wire logic [gql_pkg::NUM_PINS-1:0]                          i_qual_sample_select,
    output logic      [gql_pkg::NUM_PINS-1:0]                          o_gpio_qualified,
    // low-power control
    input  wire logic [1:0]                                            i_lpm_mode,
    input  wire logic                                                  i_idle_exec,
    input  wire logic [1:0]                                            i_clock_divider_select,
    input  wire logic [5:0]                                            i_standby_wake_qual,
    input  wire logic                                                  i_standby_qual_en,
    input  wire logic                                                  i_flash_sleep,
    input  wire logic                                                  i_wake_irq_en,
    // wake sources and oscillator clock
    input  wire logic [gql_pkg::NUM_PINS-1:0]                          i_wake_pin_mask,
    input  wire logic                                                  i_enabled_int,
    input  wire logic                                                  i_watchdog_interrupt,
    input  wire logic                                                  i_external_nonmaskable_int,
    input  wire logic                                                  i_reset_pin_n,
    input  wire logic                                                  i_oscillator_clock,
    // clock gates and status
    output logic                                                       o_system_clock_en,
    output logic                                                       o_periph_clock_en,
    output logic                                                       o_pll_watchdog_en,
    output logic                                                       o_clock_output_pin_en,
    output logic                                                       o_resume,
    output logic                                                       o_wake_irq
);
    // ------------------------------------------------------------------
    // group sample ticks and pin qualifiers
    // ------------------------------------------------------------------
    logic [gql_pkg::NUM_GROUPS-1:0] grp_tick;

    for (genvar g = 0; g < gql_pkg::NUM_GROUPS; g++) begin : g_grp
        logic [gql_pkg::PCNT_W-1:0]   pcnt;
        logic [gql_pkg::PCNT_W-1:0]   next_pcnt;
        logic [gql_pkg::PCNT_W-1:0]   last;
        logic [gql_pkg::PERIOD_W-1:0] per;
        logic                         tick;

        // tick when the divider wraps; period zero ticks every cycle
        always_comb begin
            per         = i_qual_period[g*gql_pkg::PERIOD_W +: gql_pkg::PERIOD_W];
            last        = {per, 1'b0} - 9'h001;
            tick        = (per == 8'h00) || (pcnt >= last);
            next_pcnt   = tick ? 9'h000 : pcnt + 9'h001;
        end
        assign grp_tick[g] = tick;

        always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
            if (!i_rst_n) begin
                pcnt <= gql_pkg::PCNT_RST;
            end else begin
                pcnt <= next_pcnt;
            end
        end

        property p_tick_spacing;
            @(posedge i_ref_clk) disable iff (!i_rst_n)
            (grp_tick[g] && per == 8'h03 && $stable(per)) |=> !grp_tick[g] [*5] ##1 grp_tick[g];
        endproperty
        a_tick_spacing: assert property (p_tick_spacing) else $error("tick spacing wrong");
    end

    for (genvar p = 0; p < gql_pkg::NUM_PINS; p++) begin : g_pin
        gql_qual_if qif ();
        assign qif.tick        = grp_tick[p / gql_pkg::GROUP_PINS];
        assign qif.six_sample  = i_qual_sample_select[p];
        assign qif.pin_raw     = i_gpio_pin[p];
        assign o_gpio_qualified[p] = qif.qualified;
        gql_qualifier u_qual (
            .i_ref_clk (i_ref_clk),
            .i_rst_n   (i_rst_n),
            .q         (qif.qual)
        );
    end

    // ------------------------------------------------------------------
    // low-power sequencer
    // ------------------------------------------------------------------
    gql_pkg::gql_lpm_state_t         state;
    gql_pkg::gql_lpm_state_t         next_state;
    logic [2:0]                      osc_sync;
    logic [2:0]                      next_osc_sync;
    logic                            osc_lvl;
    logic                            next_osc_lvl;
    logic [gql_pkg::ENT_W-1:0]       ent_cnt;
    logic [gql_pkg::ENT_W-1:0]       next_ent_cnt;
    logic [2:0]                      guard_cnt;
    logic [2:0]                      next_guard_cnt;
    logic [gql_pkg::WQ_W-1:0]        wq_cnt;
    logic [gql_pkg::WQ_W-1:0]        next_wq_cnt;
    logic [gql_pkg::LAT_W-1:0]       lat_cnt;
    logic [gql_pkg::LAT_W-1:0]       next_lat_cnt;
    logic [gql_pkg::LAT_W-1:0]       lat_tgt;
    logic [gql_pkg::LAT_W-1:0]       next_lat_tgt;
    logic                            wake_irq;
    logic                            next_wake_irq;
    logic                            osc_rise;
    logic                            wake_req;
    logic                            armed;
    logic                            sb_wake;
    logic [gql_pkg::ENT_W-1:0]       hold_len;
    logic                            resume_done;

    // next values of the sequencer, its counters and the oscillator sampler
    always_comb begin
        next_osc_sync  = {osc_sync[1:0], i_oscillator_clock};
        next_osc_lvl   = (osc_sync[1] == osc_sync[2]) ? osc_sync[2] : osc_lvl;
        osc_rise       = next_osc_lvl && !osc_lvl;
        wake_req       = i_enabled_int || i_watchdog_interrupt
                       || i_external_nonmaskable_int || !i_reset_pin_n
                       || |(~o_gpio_qualified & i_wake_pin_mask);
        armed          = (guard_cnt >= gql_pkg::OSC_GUARD);
        sb_wake        = wake_req && armed && (!i_standby_qual_en
                       || wq_cnt >= gql_pkg::SB_QUAL_BASE + {1'b0, i_standby_wake_qual});
        case (i_clock_divider_select)
            2'h2:    hold_len = gql_pkg::HOLD_MID;
            2'h3:    hold_len = gql_pkg::HOLD_LONG;
            default: hold_len = gql_pkg::HOLD_SHORT;
        endcase
        resume_done    = (state == gql_pkg::ST_RESUME) && (lat_cnt >= lat_tgt - 11'h001);
        next_state     = state;
        next_ent_cnt   = (ent_cnt == gql_pkg::ENT_MAX) ? ent_cnt : ent_cnt + 7'h01;
        next_guard_cnt = (osc_rise && !armed) ? guard_cnt + 3'h1 : guard_cnt;
        next_wq_cnt    = !wake_req ? 7'h00
                       : (osc_rise && wq_cnt != 7'h7F) ? wq_cnt + 7'h01 : wq_cnt;
        next_lat_cnt   = lat_cnt + 11'h001;
        next_lat_tgt   = lat_tgt;
        next_wake_irq  = resume_done && i_wake_irq_en;
        case (state)
            gql_pkg::ST_RUN: begin
                next_guard_cnt = 3'h0;
                next_ent_cnt   = 7'h00;
                if (i_idle_exec && i_lpm_mode == gql_pkg::MODE_IDLE) begin
                    next_state = gql_pkg::ST_IDLE;
                end else if (i_idle_exec && i_lpm_mode == gql_pkg::MODE_STANDBY) begin
                    next_state = gql_pkg::ST_SB_HOLD;
                end
            end
            gql_pkg::ST_IDLE: begin
                if (wake_req && armed) begin
                    next_state   = gql_pkg::ST_RESUME;
                    next_lat_cnt = 11'h000;
                    next_lat_tgt = i_flash_sleep ? gql_pkg::LAT_IDLE_SLOW
                                                 : gql_pkg::LAT_IDLE_FAST;
                end
            end
            gql_pkg::ST_SB_HOLD: begin
                if (ent_cnt >= hold_len - 7'h01) begin
                    next_state = gql_pkg::ST_STANDBY;
                end
            end
            gql_pkg::ST_STANDBY: begin
                if (sb_wake) begin
                    next_state   = gql_pkg::ST_RESUME;
                    next_lat_cnt = 11'h000;
                    next_lat_tgt = i_flash_sleep ? gql_pkg::LAT_SB_SLOW
                                                 : gql_pkg::LAT_SB_FAST;
                end
            end
            gql_pkg::ST_RESUME: begin
                if (resume_done) begin
                    next_state = gql_pkg::ST_RUN;
                end
            end
            default: begin
                next_state = gql_pkg::ST_RUN;
            end
        endcase
    end

    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            state     <= gql_pkg::ST_RUN;
            osc_sync  <= 3'h0;
            osc_lvl   <= 1'b0;
            ent_cnt   <= 7'h00;
            guard_cnt <= 3'h0;
            wq_cnt    <= 7'h00;
            lat_cnt   <= 11'h000;
            lat_tgt   <= gql_pkg::LAT_IDLE_FAST;
            wake_irq  <= 1'b0;
        end else begin
            state     <= next_state;
            osc_sync  <= next_osc_sync;
            osc_lvl   <= next_osc_lvl;
            ent_cnt   <= next_ent_cnt;
            guard_cnt <= next_guard_cnt;
            wq_cnt    <= next_wq_cnt;
            lat_cnt   <= next_lat_cnt;
            lat_tgt   <= next_lat_tgt;
            wake_irq  <= next_wake_irq;
        end
    end

    // clock gate and status outputs
    assign o_system_clock_en     = (state != gql_pkg::ST_STANDBY);
    assign o_periph_clock_en     = (state != gql_pkg::ST_STANDBY);
    assign o_pll_watchdog_en     = 1'b1;
    assign o_clock_output_pin_en = !(((state == gql_pkg::ST_SB_HOLD)
                                   || (state == gql_pkg::ST_STANDBY))
                                   && ent_cnt >= gql_pkg::CLKOUT_LOW);
    assign o_resume              = resume_done;
    assign o_wake_irq            = wake_irq;

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    property p_hold_short;
        @(posedge i_ref_clk) disable iff (!i_rst_n)
        ($rose(state == gql_pkg::ST_SB_HOLD) && i_clock_divider_select == 2'h0
            && $stable(i_clock_divider_select))
        |-> o_system_clock_en [*8] ##1 o_system_clock_en [*8] ##1 (state == gql_pkg::ST_STANDBY);
    endproperty
    a_hold_short: assert property (p_hold_short) else $error("hold length not 16");

    property p_clkout_low;
        @(posedge i_ref_clk) disable iff (!i_rst_n)
        $rose(state == gql_pkg::ST_SB_HOLD) |-> ##32
            (!o_clock_output_pin_en || state != gql_pkg::ST_STANDBY && state != gql_pkg::ST_SB_HOLD);
    endproperty
    a_clkout_low: assert property (p_clkout_low) else $error("clock output not low at 32");

    property p_periph_off;
        @(posedge i_ref_clk) disable iff (!i_rst_n)
        (state == gql_pkg::ST_STANDBY) |-> !o_periph_clock_en && o_pll_watchdog_en;
    endproperty
    a_periph_off: assert property (p_periph_off) else $error("standby clock gating wrong");

    property p_idle_fast;
        @(posedge i_ref_clk) disable iff (!i_rst_n)
        (state == gql_pkg::ST_IDLE && next_state == gql_pkg::ST_RESUME && !i_flash_sleep)
        |-> ##[1:20] o_resume;
    endproperty
    a_idle_fast: assert property (p_idle_fast) else $error("idle resume too slow");

    property p_sb_fast;
        @(posedge i_ref_clk) disable iff (!i_rst_n)
        (state == gql_pkg::ST_STANDBY && next_state == gql_pkg::ST_RESUME && !i_flash_sleep)
        |-> ##[1:100] o_resume;
    endproperty
    a_sb_fast: assert property (p_sb_fast) else $error("standby resume too slow");

    property p_idle_wake;
        @(posedge i_ref_clk) disable iff (!i_rst_n)
        (state == gql_pkg::ST_IDLE && armed && i_watchdog_interrupt)
        |=> (state == gql_pkg::ST_RESUME);
    endproperty
    a_idle_wake: assert property (p_idle_wake) else $error("watchdog did not wake idle");

    property p_guard;
        @(posedge i_ref_clk) disable iff (!i_rst_n)
        (state == gql_pkg::ST_IDLE && guard_cnt < 3'h4) |=> (state != gql_pkg::ST_RESUME);
    endproperty
    a_guard: assert property (p_guard) else $error("wake accepted inside guard");

    property p_irq_after;
        @(posedge i_ref_clk) disable iff (!i_rst_n)
        (o_resume && i_wake_irq_en) |=> o_wake_irq && (state == gql_pkg::ST_RUN);
    endproperty
    a_irq_after: assert property (p_irq_after) else $error("wake interrupt missing");

    c_idle_cycle: cover property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        (state == gql_pkg::ST_IDLE) ##[1:50] o_resume);
    c_sb_cycle: cover property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        (state == gql_pkg::ST_STANDBY) ##[1:200] o_resume);
    c_long_hold: cover property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        (state == gql_pkg::ST_SB_HOLD && ent_cnt == 7'h3F));
endmodule

// [sim/gql_src_model.sv]
// external pin drivers and the free-running oscillator clock
`timescale 1ns/1ps
module gql_src_model (
    // oscillator and pins
    output logic        o_osc_clk,
    output logic [15:0] o_pin
);
    // oscillator runs free and is unrelated in phase to the system clock
    initial begin
        o_osc_clk = 1'b0;
        o_pin     = 16'h8000;
        forever #18.5 o_osc_clk = ~o_osc_clk;
    end
    // new level is held until the bench changes it again
    task automatic drive(input int p, input logic lvl);
        o_pin[p] = lvl;
    endtask
    // short pulse that the qualifier must drop
    task automatic glitch(input int p, input int w_ns);
        o_pin[p] = ~o_pin[p];
        #(w_ns);
        o_pin[p] = ~o_pin[p];
    endtask
    // guard time after entry before any wake is started
    task automatic wait_osc(input int k);
        repeat (k) @(posedge o_osc_clk);
    endtask
endmodule

// [sim/tb.sv]
// bench for the pin qualifier and low-power sequencer
`timescale 1ns/1ps
module tb;
    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic [15:0] qprd = 16'h0300;
    logic [15:0] qsel = 16'hFF00;
    logic [1:0]  mode = 2'h0;
    logic        exec = 1'b0;
    logic [1:0]  div_sel = 2'h0;
    logic        sb_qen = 1'b0;
    logic        fsleep = 1'b0;
    logic        irq_en = 1'b1;
    logic [15:0] wmask = 16'h0000;
    logic [3:0]  src = 4'h0;
    logic [15:0] pin, qual;
    logic        osc, sys_en, per_en, pll_en, co_en, resume, wirq;
    wire  [5:0]  stat = {wirq, resume, co_en, pll_en, per_en, sys_en};
    int          num_errors = 0;
    int          check_count = 0;
    int          n, ts, tc, hold;
    gql_src_model src_u (.o_osc_clk(osc), .o_pin(pin));
    gql_top dut_u (
        .i_ref_clk(clk), .i_rst_n(rst_n), .i_gpio_pin(pin), .i_qual_period(qprd),
        .i_qual_sample_select(qsel), .o_gpio_qualified(qual), .i_lpm_mode(mode),
        .i_idle_exec(exec), .i_clock_divider_select(div_sel), .i_standby_wake_qual(6'h03),
        .i_standby_qual_en(sb_qen), .i_flash_sleep(fsleep), .i_wake_irq_en(irq_en),
        .i_wake_pin_mask(wmask), .i_enabled_int(src[0]), .i_watchdog_interrupt(src[1]),
        .i_external_nonmaskable_int(src[2]), .i_reset_pin_n(~src[3]),
        .i_oscillator_clock(osc), .o_system_clock_en(sys_en), .o_periph_clock_en(per_en),
        .o_pll_watchdog_en(pll_en), .o_clock_output_pin_en(co_en), .o_resume(resume),
        .o_wake_irq(wirq)
    );
    // 250 MHz system clock
    initial begin
        forever #2 clk = ~clk;
    end
    // value compare
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        check_count++;
        if (got !== exp) begin
            num_errors++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // cycle count compare against a band
    task automatic chk_rng(input int got, input int lo, input int hi);
        chk(16'((got >= lo && got <= hi) ? lo : got), 16'(lo));
    endtask
    // cycles until a status bit (s=1) or qualified pin (s=0) reaches a level
    task automatic wait_bit(input logic s, input int b, input logic lvl, output int k);
        k = 0;
        while ((s ? stat[b] : qual[b]) !== lvl && k < 1300) begin
            @(negedge clk);
            k++;
        end
    endtask
    // one-cycle idle instruction with a mode
    task automatic enter(input logic [1:0] m);
        @(negedge clk);
        mode = m;
        exec = 1'b1;
        @(negedge clk);
        exec = 1'b0;
    endtask
    // wait out the oscillator guard before waking
    task automatic wake_guard;
        src_u.wait_osc(4);
        repeat (4) @(negedge clk);
    endtask
    // summary and verdict
    task automatic print_verdict;
        $display("errors=%0d checks=%0d", num_errors, check_count);
        if (num_errors == 0 && check_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    // watchdog against a hang
    initial begin
        #200000;
        num_errors++;
        print_verdict();
    end
    // ---------------------------------------------------------------
    // main sequence
    // ---------------------------------------------------------------
    initial begin
        repeat (16) @(negedge clk);
        rst_n = 1'b1;
        chk({qual[7:0], 2'h0, stat}, 16'h000F);
        src_u.glitch(0, 4);
        repeat (10) @(negedge clk);
        chk(qual, 16'h0000);
        src_u.drive(0, 1'b1);
        wait_bit(0, 0, 1'b1, n);
        chk_rng(n, 2, 8);
        src_u.glitch(8, 48);
        repeat (60) @(negedge clk);
        chk(qual & 16'h0100, 16'h0000);
        src_u.drive(8, 1'b1);
        wait_bit(0, 8, 1'b1, n);
        chk_rng(n, 30, 47);
        wait_bit(0, 15, 1'b1, n);
        wmask = 16'h8000;
        enter(2'h3);
        repeat (40) @(negedge clk);
        chk({10'h0, stat}, 16'h000F);
        for (int i = 0; i < 5; i++) begin
            fsleep = (i == 1);
            enter(2'h1);
            wake_guard();
            if (i < 4) src[i] = 1'b1;
            else src_u.drive(15, 1'b0);
            wait_bit(1, 4, 1'b1, n);
            chk_rng(n, (i == 4) ? 30 : 1, (i == 1) ? 1051 : (i == 4) ? 80 : 21);
            @(negedge clk);
            chk({10'h0, stat}, 16'h002F);
            src = 4'h0;
            src_u.drive(15, 1'b1);
            wait_bit(0, 15, 1'b1, n);
        end
        for (int d = 0; d < 4; d++) begin
            div_sel = 2'(d);
            irq_en = (d != 0);
            sb_qen = (d == 3);
            fsleep = (d == 3);
            hold = 16 << ((d < 2) ? 0 : d - 1);
            enter(2'h2);
            ts = 0;
            tc = 0;
            for (int c = 1; c < 90; c++) begin
                @(negedge clk);
                if (ts == 0 && sys_en === 1'b0) ts = c;
                if (tc == 0 && co_en === 1'b0) tc = c;
            end
            chk_rng(ts, hold - 2, hold + 1);
            chk_rng(tc, 31, 45);
            chk({12'h0, stat[3:0]}, 16'h0004);
            wake_guard();
            src[1] = 1'b1;
            wait_bit(1, 4, 1'b1, n);
            chk_rng(n, 1, (d == 3) ? 1190 : 101);
            @(negedge clk);
            chk({10'h0, stat}, {10'h0, irq_en, 5'h0F});
            src = 4'h0;
        end
        print_verdict();
    end
endmodule
